// File: design/ioxd_defs.svh
/*
 Constants for the I/O execute unit: instruction fields, register offsets,
 register field positions, reset values and timing counts.
 Assumes inclusion by bare name from files under design/.
*/
`ifndef IOXD_DEFS_SVH
`define IOXD_DEFS_SVH

// Instruction encoding
`define IOXD_OPC_HI 5
`define IOXD_OPC_VAL 5'h1D
`define IOXD_ADDR_W 11
`define IOXD_ADDR_SPACE 2048

// Register byte offsets
`define IOXD_REG_CTRL 12'h000
`define IOXD_REG_INSTR 12'h004
`define IOXD_REG_ACC 12'h008
`define IOXD_REG_STAT 12'h00C
`define IOXD_REG_RDATA 12'h010
`define IOXD_REG_CNT 12'h014

// Control register fields
`define IOXD_CTRL_PRIV 0
`define IOXD_CTRL_RST 32'h0000_0000

// Status register fields
`define IOXD_ST_BUSY 0
`define IOXD_ST_PRIV_ERR 1
`define IOXD_ST_DONE 2
`define IOXD_ST_OPC_ERR 3
`define IOXD_ST_FIFO_LVL 8

// Timing: execute time of the instruction, in ns, at 100 MHz
`define IOXD_EXEC_NS 1700
`define IOXD_CLK_NS 10
`define IOXD_EXEC_CYC ((`IOXD_EXEC_NS) / (`IOXD_CLK_NS))

`endif

// File: design/ioxd_pkg.sv
/*
 Types shared by the I/O execute unit and its FIFO.
 Assumes ioxd_defs.svh sits beside it.
*/
`include "ioxd_defs.svh"

package ioxd_pkg;
    // Bus cycle towards a peripheral
    typedef struct packed {
        logic sel;
        logic wr;
        logic [`IOXD_ADDR_W-1:0] addr;
        logic [15:0] wdata;
    } ioxd_bus_req_t;

    // Entry of the read-data FIFO
    typedef struct packed {
        logic [`IOXD_ADDR_W-1:0] addr;
        logic [15:0] data;
    } ioxd_rd_word_t;

    // Execute sequencer, Gray coded along the usual path
    typedef enum logic [1:0] {
        IOXD_IDLE = 2'b00,
        IOXD_SETUP = 2'b01,
        IOXD_XFER = 2'b11,
        IOXD_DONE = 2'b10
    } ioxd_state_t;
endpackage

// File: design/ioxd_fifo.sv
/*
 Flip-flop FIFO with valid/ready on both sides, width and depth parameters.
 Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

module ioxd_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // Honest flags straight from the count
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];
    assign level = cnt_q;

    // Pointer and count next values
    always_comb begin
        wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage has no reset; only words below the count are ever read
    always_ff @(posedge pclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_q <= DEPTH[AW:0]) else $error("FIFO count above depth");
endmodule

`default_nettype wire

// File: design/ioxd_top.sv
/*
 I/O execute unit: takes an instruction word and accumulator over APB,
 checks the opcode and privilege, runs one bus cycle to the addressed
 peripheral and queues input words in a FIFO read back over APB.
 Assumes peripherals answer in the fixed execute time and decode their
 own addresses.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ioxd_defs.svh"

module ioxd_top #(
    parameter int FIFO_DEPTH = 32,
    parameter int EXEC_CYC = `IOXD_EXEC_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // I/O bus towards peripherals
    output ioxd_pkg::ioxd_bus_req_t io_req,
    input wire logic [15:0] io_rdata
);
    import ioxd_pkg::*;

    localparam int LW = $clog2(FIFO_DEPTH) + 1;
    localparam int CW = $clog2(EXEC_CYC + 1);

    ioxd_state_t st_q, st_d;
    ioxd_bus_req_t req_q, req_d;
    logic [15:0] instr_q, instr_d, acc_q, acc_d;
    logic priv_q, priv_d, priv_err_q, priv_err_d, opc_err_q, opc_err_d;
    logic done_q, done_d;
    logic [CW-1:0] tmr_q, tmr_d;
    logic [31:0] xfer_cnt_q, xfer_cnt_d;
    logic apb_wr, apb_rd, addr_ok, exec_go;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
    ioxd_rd_word_t fifo_in, fifo_out;
    logic [LW-1:0] fifo_lvl;

    // Access phase strobes; every access completes at once
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign addr_ok = (paddr == `IOXD_REG_CTRL) || (paddr == `IOXD_REG_INSTR) ||
                     (paddr == `IOXD_REG_ACC) || (paddr == `IOXD_REG_STAT) ||
                     (paddr == `IOXD_REG_RDATA) || (paddr == `IOXD_REG_CNT);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    // Writing the instruction register starts execution when idle
    assign exec_go = apb_wr && (paddr == `IOXD_REG_INSTR) && (st_q == IOXD_IDLE);
    // Reading the data register pops one input word
    assign fifo_pop = apb_rd && (paddr == `IOXD_REG_RDATA) && fifo_out_valid;

    // Read mux; unmapped offsets read zero
    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            `IOXD_REG_CTRL: prdata[`IOXD_CTRL_PRIV] = priv_q;
            `IOXD_REG_INSTR: prdata[15:0] = instr_q;
            `IOXD_REG_ACC: prdata[15:0] = acc_q;
            `IOXD_REG_STAT: begin
                prdata[`IOXD_ST_BUSY] = (st_q != IOXD_IDLE);
                prdata[`IOXD_ST_PRIV_ERR] = priv_err_q;
                prdata[`IOXD_ST_DONE] = done_q;
                prdata[`IOXD_ST_OPC_ERR] = opc_err_q;
                prdata[`IOXD_ST_FIFO_LVL +: LW] = fifo_lvl;
            end
            `IOXD_REG_RDATA: prdata[26:0] = fifo_out_valid ? fifo_out : 27'h0000000;
            `IOXD_REG_CNT: prdata = xfer_cnt_q;
            default: prdata = 32'h0000_0000;
        endcase
    end

    // Sequencer: check, setup, timed transfer, completion
    always_comb begin
        st_d = st_q;
        req_d = req_q;
        instr_d = instr_q;
        acc_d = acc_q;
        priv_d = priv_q;
        priv_err_d = priv_err_q;
        opc_err_d = opc_err_q;
        done_d = done_q;
        tmr_d = tmr_q;
        xfer_cnt_d = xfer_cnt_q;
        fifo_in_valid = 1'b0;
        fifo_in.addr = req_q.addr;
        fifo_in.data = io_rdata;
        if (apb_wr && paddr == `IOXD_REG_CTRL) begin
            priv_d = pwdata[`IOXD_CTRL_PRIV];
        end
        if (apb_wr && paddr == `IOXD_REG_ACC) begin
            acc_d = pwdata[15:0];
        end
        // Reading status clears sticky flags, unless the sequencer sets them now
        if (apb_rd && paddr == `IOXD_REG_STAT) begin
            priv_err_d = 1'b0;
            opc_err_d = 1'b0;
            done_d = 1'b0;
        end
        unique case (st_q)
            IOXD_IDLE: begin
                if (exec_go) begin
                    instr_d = pwdata[15:0];
                    if (pwdata[15:11] != `IOXD_OPC_VAL) begin
                        opc_err_d = 1'b1;
                    end else if (!priv_q) begin
                        priv_err_d = 1'b1;
                    end else begin
                        st_d = IOXD_SETUP;
                        req_d.addr = pwdata[`IOXD_ADDR_W-1:0];
                        req_d.wr = pwdata[0];
                        req_d.wdata = acc_q;
                    end
                end
            end
            IOXD_SETUP: begin
                // Select asserted for the whole timed window
                req_d.sel = 1'b1;
                tmr_d = CW'(EXEC_CYC - 1);
                st_d = IOXD_XFER;
            end
            IOXD_XFER: begin
                if (tmr_q == '0) begin
                    // Input word sampled at the close; stalls while FIFO is full
                    if (req_q.wr || fifo_in_ready) begin
                        fifo_in_valid = !req_q.wr;
                        req_d.sel = 1'b0;
                        st_d = IOXD_DONE;
                    end
                end else begin
                    tmr_d = CW'(tmr_q - 1'b1);
                end
            end
            IOXD_DONE: begin
                done_d = 1'b1;
                xfer_cnt_d = xfer_cnt_q + 32'h0000_0001;
                st_d = IOXD_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= IOXD_IDLE;
            req_q <= '0;
            instr_q <= 16'h0000;
            acc_q <= 16'h0000;
            priv_q <= 1'b0;
            priv_err_q <= 1'b0;
            opc_err_q <= 1'b0;
            done_q <= 1'b0;
            tmr_q <= '0;
            xfer_cnt_q <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
            req_q <= req_d;
            instr_q <= instr_d;
            acc_q <= acc_d;
            priv_q <= priv_d;
            priv_err_q <= priv_err_d;
            opc_err_q <= opc_err_d;
            done_q <= done_d;
            tmr_q <= tmr_d;
            xfer_cnt_q <= xfer_cnt_d;
        end
    end

    assign io_req = req_q;

    ioxd_fifo #(
        .WIDTH(27),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out),
        .level(fifo_lvl)
    );

    // Checks
    a_priv_reject: assert property (@(posedge pclk) disable iff (!presetn)
        exec_go && pwdata[15:11] == `IOXD_OPC_VAL && !priv_q
        |=> st_q == IOXD_IDLE && priv_err_q)
        else $error("unprivileged execute not rejected");
    a_opcode_check: assert property (@(posedge pclk) disable iff (!presetn)
        exec_go && pwdata[15:11] != `IOXD_OPC_VAL |=> st_q == IOXD_IDLE && opc_err_q)
        else $error("bad opcode not refused");
    a_addr_field: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == IOXD_SETUP |-> req_q.addr == instr_q[10:0])
        else $error("address field mismatch");
    a_sel_start: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == IOXD_SETUP |=> io_req.sel)
        else $error("select not asserted");
    a_sel_only_exec: assert property (@(posedge pclk) disable iff (!presetn)
        io_req.sel |-> st_q == IOXD_XFER)
        else $error("select outside execute");
    a_dir_bit: assert property (@(posedge pclk) disable iff (!presetn)
        io_req.sel |-> io_req.wr == io_req.addr[0])
        else $error("direction not from bit 0");
    a_sel_stable: assert property (@(posedge pclk) disable iff (!presetn)
        io_req.sel && tmr_q != '0 |=> io_req.sel && $stable(io_req.addr))
        else $error("select dropped early");
    a_done_follow: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == IOXD_DONE |=> done_q && st_q == IOXD_IDLE)
        else $error("completion not flagged");

    c_write_xfer: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == IOXD_DONE && req_q.wr);
    c_read_xfer: cover property (@(posedge pclk) disable iff (!presetn)
        fifo_in_valid);
    c_priv_fail: cover property (@(posedge pclk) disable iff (!presetn)
        priv_err_q);
    c_fifo_full: cover property (@(posedge pclk) disable iff (!presetn)
        !fifo_in_ready);
endmodule

`default_nettype wire

// File: bench/ioxd_periph_model.sv
/*
 Peripheral model on the I/O bus: terminals and mass storage devices.
 Assumes the unit holds io_req steady while sel is high.
*/
`timescale 1ns/10ps
`default_nettype none

module ioxd_periph_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // I/O bus
    input wire ioxd_pkg::ioxd_bus_req_t io_req,
    output logic [15:0] io_rdata,
    // Data of the last matching output transfer
    output logic [15:0] wr_seen
);
    import ioxd_pkg::*;
    logic hit;
    logic [15:0] last_q;

    // Only maker groups 3 and 5 answer, eight consecutive addresses per unit
    // Extended or customer addresses are left to other cards
    assign hit = io_req.sel && io_req.addr[10:9] == 2'b00
        && (io_req.addr[8:6] == 3'h3 || io_req.addr[8:6] == 3'h5);
    // Terminal and drum register sets share one decode
    // Read data only on input; idle lines show the inverse value
    assign io_rdata = (hit && !io_req.wr) ? ({5'h00, io_req.addr} ^ 16'hC3C3) : ~last_q;

    // wr_seen captures only on a matching output, last_q every cycle; read and write use separate addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= 16'h0000;
            wr_seen <= 16'h0000;
        end else begin
            last_q <= io_rdata;
            if (hit && io_req.wr) wr_seen <= io_req.wdata;
        end
    end
endmodule

`default_nettype wire

// File: bench/test_io_device_address_decode.sv
/*
 Bench for the I/O execute unit: APB tasks and ordered tests with expected values.
 Assumes the design header, package and modules and the peripheral model come first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ioxd_defs.svh"

module test_io_device_address_decode;
    import ioxd_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, sel_prev = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] io_rdata, seen;
    ioxd_bus_req_t io_req, last_req;
    int fail_count = 0, check_count = 0, sel_cnt = 0;
    logic [10:0] rd_tab [5] = '{11'o300, 11'o302, 11'o310, 11'o540, 11'o542};
    logic [10:0] wr_tab [4] = '{11'o305, 11'o303, 11'o541, 11'o547};

    // Short execute time and a small FIFO keep the stall case quick
    ioxd_top #(.FIFO_DEPTH(4), .EXEC_CYC(3)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_req(io_req),
        .io_rdata(io_rdata));
    ioxd_periph_model periph (.pclk(pclk), .presetn(presetn), .io_req(io_req),
        .io_rdata(io_rdata), .wr_seen(seen));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Count bus cycles and keep the last request, so refusals show up
    always @(posedge pclk) begin
        sel_prev <= io_req.sel;
        if (io_req.sel === 1'b1) last_req <= io_req;
        if (io_req.sel === 1'b1 && sel_prev !== 1'b1) sel_cnt <= sel_cnt + 1;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            finish_test();
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdreg(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000, rd, e);
        chk(what, exp, rd);
    endtask

    // Poll status until busy drops; a long wait ends the run
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, `IOXD_REG_STAT, 32'h0000_0000, rd, e);
            n++;
        end while (rd[`IOXD_ST_BUSY] !== 1'b0 && n < 100);
        if (n >= 100) begin
            fail_count++;
            finish_test();
        end
    endtask

    task automatic io_execute_instruction(input logic [4:0] opc, input logic [10:0] a, input logic idle);
        apb(1'b1, `IOXD_REG_INSTR, {16'h0000, opc, a}, rd, e);
        if (idle) wait_idle();
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and the unmapped hole
        rdreg(`IOXD_REG_CTRL, 32'h0000_0000, "ctrl reset");
        rdreg(`IOXD_REG_CNT, 32'h0000_0000, "count reset");
        apb(1'b0, 12'h018, 32'h0000_0000, rd, e);
        chk("unmapped err", 32'h0000_0001, {31'h0, e});
        // No privilege, then a bad opcode: flagged, cleared by reading, no bus cycle
        io_execute_instruction(`IOXD_OPC_VAL, 11'o300, 1'b0);
        rdreg(`IOXD_REG_STAT, 32'h0000_0002, "priv err");
        rdreg(`IOXD_REG_STAT, 32'h0000_0000, "flag clear");
        apb(1'b1, `IOXD_REG_CTRL, 32'h0000_0001, rd, e);
        rdreg(`IOXD_REG_CTRL, 32'h0000_0001, "ctrl rw");
        io_execute_instruction(5'h1C, 11'o300, 1'b0);
        rdreg(`IOXD_REG_STAT, 32'h0000_0008, "opcode err");
        chk("refused cycles", 32'h0, sel_cnt);
        // Output transfers carry the accumulator to the addressed register
        foreach (wr_tab[i]) begin
            apb(1'b1, `IOXD_REG_ACC, 32'h0000_1200 + i, rd, e);
            io_execute_instruction(`IOXD_OPC_VAL, wr_tab[i], 1'b1);
            chk("write addr", {21'h0, wr_tab[i]}, {21'h0, last_req.addr});
            chk("write dir", 32'h1, {31'h0, last_req.wr});
            chk("write data", 32'h0000_1200 + i, {16'h0, seen});
        end
        // Accumulator alone moves nothing; a customer address uses all eleven bits
        apb(1'b1, `IOXD_REG_ACC, 32'h0000_BEEF, rd, e);
        chk("acc only", 32'h4, sel_cnt);
        io_execute_instruction(`IOXD_OPC_VAL, 11'o2305, 1'b1);
        chk("full addr", {21'h0, 11'o2305}, {21'h0, last_req.addr});
        chk("no match", 32'h0000_1203, {16'h0, seen});
        // An extended group address is not decoded by the standard cards
        io_execute_instruction(`IOXD_OPC_VAL, 11'o1305, 1'b1);
        chk("ext group", 32'h0000_1203, {16'h0, seen});
        // Input words fill the FIFO until the fifth stalls the bus
        foreach (rd_tab[i]) begin
            io_execute_instruction(`IOXD_OPC_VAL, rd_tab[i], i < 4);
        end
        repeat (10) @(posedge pclk);
        apb(1'b0, `IOXD_REG_STAT, 32'h0000_0000, rd, e);
        chk("stall status", 32'h0000_0401, rd & 32'h0000_7F01);
        chk("stall sel", 32'h1, {31'h0, io_req.sel});
        // A new instruction while busy is ignored
        io_execute_instruction(`IOXD_OPC_VAL, 11'o307, 1'b0);
        rdreg(`IOXD_REG_INSTR, {16'h0000, `IOXD_OPC_VAL, 11'o542}, "busy ignore");
        foreach (rd_tab[i]) begin
            rdreg(`IOXD_REG_RDATA, {5'h00, rd_tab[i], {5'h00, rd_tab[i]} ^ 16'hC3C3},
                  "rdata");
            if (i == 0) wait_idle();
        end
        rdreg(`IOXD_REG_RDATA, 32'h0000_0000, "empty");
        rdreg(`IOXD_REG_CNT, 32'd11, "count");
        finish_test();
    end
endmodule

`default_nettype wire
